/* File: design/tcmf_cfg.svh */
// constants of the channel multiplexer framer: patterns, slot map, counts
// assumes the includer compiles it once per unit; guarded against repeats
`ifndef TCMF_CFG_SVH
`define TCMF_CFG_SVH
`define TCMF_ALARM_BYTE    8'h0F
`define TCMF_FB24          12'h3B1
`define TCMF_DATA_CAP      24'h555FFF
`define TCMF_GRP_A         3'h4
`define TCMF_GRP_B         3'h3
`define TCMF_STUFF         2'h2
`define TCMF_FR_SIG_A      5'h05
`define TCMF_FR_SIG_B24    5'h0B
`define TCMF_FR_SIG_B      5'h11
`define TCMF_FR_FRM_A      5'h0B
`define TCMF_FR_FRM_B      5'h17
`define TCMF_TX_DIV        32'h51
`define TCMF_EXT_WIN       32'h100
`define TCMF_LOS_CYC       32'h400
`define TCMF_SYNC_GOOD     3'h4
`define TCMF_SYNC_BAD      3'h3
`define TCMF_REMOTE_FRAMES 4'h8
`define TCMF_TEST_DIV      12'h040
`endif

/* File: design/tcmf_pkg.sv */
// types shared by the channel multiplexer framer
// assumes tcmf_cfg.svh supplies the numeric constants
package tcmf_pkg;
  typedef enum logic [1:0] {MD_3, MD_6, MD_12, MD_24} tcmf_mode_e;
  typedef enum logic [1:0] {SL_VOICE, SL_SYNC, SL_ASYNC20, SL_ASYNC50} tcmf_slot_e;
  typedef enum logic [2:0] {RT_56, RT_64, RT_128, RT_256, RT_512} tcmf_rate_e;
  typedef struct packed {
    tcmf_mode_e mode;
    logic       bipolar;
    tcmf_rate_e mr_rate;
    logic [4:0] mr_base;
    logic [1:0] test_rate;
  } tcmf_cfg_s;
  typedef struct packed {
    logic loss_input;
    logic remote;
    logic loss_frame;
    logic loss_output;
  } tcmf_alarm_s;
endpackage

/* File: design/tcmf_framer.sv */
// channel multiplexer framer: transmit framer on mclk, receive framer on link clock
// assumes straps and slot types are static; channel units follow the strobes
// Notes on behaviour
// - 24 slots carry voice; only slots 1-12 and odd slots above carry data
// - framing mode 3, 6, 12 or 24 channels; NRZ or bipolar line format
// - low-rate async slot sends a two-bit transition code in its word
// - 50k async slot puts stuff bits in the two lowest bit places
// - multirate strap 56 to 512k takes one slot per 64k step
// - transmit side drives 24 one-hot channel select strobes
// - during input, frame or output loss the stream carries 00001111 instead of channel data
// - transmit clock follows external timing if present, else internal
// - bipolar format leaves the transmit clock pin undriven
// - received data passes a small buffer clocked by the link clock
// - receiver finds framing, aligns counters, monitors frame errors
// - receiver hands out serial data and channel and bit counters
// - detect input loss, remote alarm, frame loss, output loss; tell far end
// - alarm busies voice channels and forces data outputs to all ones
// - loop tests force the same busy-out and all ones
// - alarm clears and service resumes by itself when cause goes
// - remote group alarm is passed to voice units to drop calls
// - test unit sends a pattern and flags errors in the looped return
// - 24-channel frame: ascending words then one framing bit, 12-frame superframe
// - small modes: framing in B8 of ch 1-3, frames 12 and 24, 001 then 110
`timescale 1ns/1ps
`default_nettype none
`include "tcmf_cfg.svh"
module tcmf_framer #(
  parameter int TX_DIV  = `TCMF_TX_DIV,
  parameter int EXT_WIN = `TCMF_EXT_WIN,
  parameter int LOS_CYC = `TCMF_LOS_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  aggregate_rx_clock,
  input  wire logic                  aggregate_rx_data,
  input  wire logic                  ext_timing,
  input  wire tcmf_pkg::tcmf_cfg_s   cfg,
  input  wire tcmf_pkg::tcmf_slot_e  slot_type [24],
  input  wire logic                  loop_local,
  input  wire logic                  loop_remote,
  input  wire logic                  chan_tx_bit,
  input  wire logic                  sig_tx_bit,
  input  wire logic                  async_in,
  input  wire logic                  tx_line_ok,
  input  wire logic                  test_rx_bit,
  output logic                       aggregate_tx_data,
  output logic                       aggregate_tx_clock,
  output logic                       aggregate_tx_clock_oe,
  output logic [23:0]                channel_select_strobes,
  output tcmf_pkg::tcmf_alarm_s      alarm_status,
  output logic                       voice_busy,
  output logic                       data_all_ones,
  output logic                       remote_group_alarm,
  output logic                       test_tx_bit,
  output logic                       test_error,
  output logic                       rx_chan_data,
  output logic [4:0]                 rx_chan_index,
  output logic [2:0]                 rx_bit_index,
  output logic                       rx_in_sync
);
  localparam logic [23:0] CAP = `TCMF_DATA_CAP;
  function automatic logic [4:0] last_ch(input tcmf_pkg::tcmf_mode_e m);
    case (m)
      tcmf_pkg::MD_3:  last_ch = 5'h02;
      tcmf_pkg::MD_6:  last_ch = 5'h05;
      tcmf_pkg::MD_12: last_ch = 5'h0B;
      default:         last_ch = 5'h17;
    endcase
  endfunction

  // named copies: a bit can be picked from these, not from a bare literal
  localparam logic [11:0] FB24  = `TCMF_FB24;
  localparam logic [7:0]  ALARM = `TCMF_ALARM_BYTE;
  localparam logic [2:0]  GRP_A = `TCMF_GRP_A;
  localparam logic [2:0]  GRP_B = `TCMF_GRP_B;
  localparam logic [1:0]  STUFF = `TCMF_STUFF;
  logic rx_tog, rx_sync, rx_remote;

  // pin synchronisers; stage 0 feeds only stage 1
  logic [2:0] ext_m, rtog_m;
  logic [1:0] chan_m, sig_m, async_m, line_m, test_m, sync_m, rem_m;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {ext_m, rtog_m, chan_m, sig_m, async_m, line_m, test_m, sync_m, rem_m} <= '0;
    end else begin
      ext_m   <= {ext_m[1:0], ext_timing};
      rtog_m  <= {rtog_m[1:0], rx_tog};
      chan_m  <= {chan_m[0], chan_tx_bit};
      sig_m   <= {sig_m[0], sig_tx_bit};
      async_m <= {async_m[0], async_in};
      line_m  <= {line_m[0], tx_line_ok};
      test_m  <= {test_m[0], test_rx_bit};
      sync_m  <= {sync_m[0], rx_sync};
      rem_m   <= {rem_m[0], rx_remote};
    end
  end

  // effective slot use: incapable slots stay voice, multirate claims a run
  logic [3:0] mr_n;
  tcmf_pkg::tcmf_slot_e eff [24];
  always_comb begin
    case (cfg.mr_rate)
      tcmf_pkg::RT_128: mr_n = 4'h2;
      tcmf_pkg::RT_256: mr_n = 4'h4;
      tcmf_pkg::RT_512: mr_n = 4'h8;
      default:          mr_n = 4'h1;
    endcase
  end
  for (genvar i = 0; i < 24; i++) begin : g_slot
    logic in_mr;
    assign in_mr = (6'(i) >= {1'b0, cfg.mr_base}) &&
                   (6'(i) < {1'b0, cfg.mr_base} + {2'b0, mr_n});
    assign eff[i] = !CAP[i] ? tcmf_pkg::SL_VOICE :
                    in_mr ? tcmf_pkg::SL_SYNC : slot_type[i];
  end

  // transmit framer
  logic [7:0] div, next_div;
  logic [9:0] ext_cnt, next_ext_cnt;
  logic ext_on, next_ext_on, tick, ext_edge;
  logic [2:0] bit_i, next_bit_i;
  logic [4:0] ch, next_ch, frm, next_frm;
  logic fb, next_fb, alast, next_alast, v, next_txclk;
  logic [23:0] next_strobes;
  logic force_tx, smallf, sigf;
  tcmf_pkg::tcmf_slot_e ty;
  assign ext_edge = ext_m[1] & ~ext_m[2];
  assign tick = ext_on ? ext_edge : (div == 8'(TX_DIV - 1));
  assign force_tx = alarm_status.loss_input | alarm_status.loss_frame |
                    alarm_status.loss_output | loop_local | loop_remote;
  always_comb begin
    next_div = (div == 8'(TX_DIV - 1)) ? 8'h00 : div + 8'h01;
    next_ext_on = ext_on;
    next_ext_cnt = ext_cnt;
    if (ext_edge) begin
      next_ext_cnt = '0;
      next_ext_on = 1'b1;
    end else if (ext_cnt == 10'(EXT_WIN - 1)) begin
      next_ext_on = 1'b0;
    end else begin
      next_ext_cnt = ext_cnt + 10'h001;
    end
    next_txclk = ext_on ? ext_m[2] : (div < 8'(TX_DIV / 2));
    ty = eff[ch];
    sigf = (frm == `TCMF_FR_SIG_A) ||
           (frm == ((cfg.mode == tcmf_pkg::MD_24) ? `TCMF_FR_SIG_B24 : `TCMF_FR_SIG_B));
    smallf = (cfg.mode != tcmf_pkg::MD_24) && (ch < 5'h03) && (bit_i == 3'h7) &&
             (frm == `TCMF_FR_FRM_A || frm == `TCMF_FR_FRM_B);
    if (fb) begin
      v = FB24[frm[3:0]];
    end else if (smallf) begin
      v = (frm == `TCMF_FR_FRM_A) ? GRP_A[ch[1:0]] : GRP_B[ch[1:0]];
    end else if (force_tx) begin
      v = ALARM[3'h7 - bit_i];
    end else begin
      case (ty)
        tcmf_pkg::SL_VOICE:   v = (bit_i == 3'h7 && sigf) ? sig_m[1] : chan_m[1];
        tcmf_pkg::SL_ASYNC20: v = bit_i[0] ? async_m[1] : (async_m[1] ^ alast);
        tcmf_pkg::SL_ASYNC50: v = (bit_i >= 3'h6) ? STUFF[bit_i[0]] : chan_m[1];
        default: v = (bit_i == 3'h7 && cfg.mr_rate == tcmf_pkg::RT_56) ? 1'b1 : chan_m[1];
      endcase
    end
    next_bit_i = bit_i;
    next_ch = ch;
    next_frm = frm;
    next_fb = fb;
    next_alast = alast;
    if (tick) begin
      if (fb) begin
        next_fb = 1'b0;
      end else if (bit_i == 3'h7) begin
        next_bit_i = 3'h0;
        next_alast = async_m[1];
        if (ch == last_ch(cfg.mode)) begin
          next_ch = 5'h00;
          next_fb = (cfg.mode == tcmf_pkg::MD_24);
          if (frm == ((cfg.mode == tcmf_pkg::MD_24) ? `TCMF_FR_SIG_B24 : `TCMF_FR_FRM_B))
            next_frm = 5'h00;
          else
            next_frm = frm + 5'h01;
        end else begin
          next_ch = ch + 5'h01;
        end
      end else begin
        next_bit_i = bit_i + 3'h1;
      end
    end
    next_strobes = fb ? 24'h000000 : (24'h000001 << ch);
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {div, ext_cnt, ext_on, bit_i, ch, frm, fb, alast} <= '0;
      {aggregate_tx_data, aggregate_tx_clock, aggregate_tx_clock_oe} <= '0;
      channel_select_strobes <= '0;
    end else begin
      div <= next_div;
      ext_cnt <= next_ext_cnt;
      ext_on <= next_ext_on;
      bit_i <= next_bit_i;
      ch <= next_ch;
      frm <= next_frm;
      fb <= next_fb;
      alast <= next_alast;
      aggregate_tx_data <= tick ? v : aggregate_tx_data;
      aggregate_tx_clock <= next_txclk;
      aggregate_tx_clock_oe <= !cfg.bipolar;
      channel_select_strobes <= next_strobes;
    end
  end

  // alarm collection; levels, so clearing follows the cause
  logic [11:0] los_cnt, next_los_cnt;
  tcmf_pkg::tcmf_alarm_s next_alarm;
  logic next_busy;
  always_comb begin
    next_los_cnt = (rtog_m[1] ^ rtog_m[2]) ? 12'h000 :
                   (los_cnt == 12'(LOS_CYC - 1)) ? los_cnt : los_cnt + 12'h001;
    next_alarm.loss_input  = (los_cnt == 12'(LOS_CYC - 1));
    next_alarm.remote      = rem_m[1];
    next_alarm.loss_frame  = !sync_m[1];
    next_alarm.loss_output = !line_m[1];
    next_busy = (|next_alarm) | loop_local | loop_remote;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      los_cnt <= '0;
      alarm_status <= '0;
      {voice_busy, data_all_ones, remote_group_alarm, rx_in_sync} <= '0;
    end else begin
      los_cnt <= next_los_cnt;
      alarm_status <= next_alarm;
      voice_busy <= next_busy;
      data_all_ones <= next_busy;
      remote_group_alarm <= next_alarm.remote;
      rx_in_sync <= sync_m[1];
    end
  end

  // test unit: 9-stage pseudo-random source, self-synchronising checker
  logic [11:0] tdiv, next_tdiv;
  logic [8:0] prbs, next_prbs, rxh, next_rxh;
  logic ttick, next_terr, next_ttx;
  assign ttick = (tdiv == ((`TCMF_TEST_DIV << cfg.test_rate) - 12'h001));
  always_comb begin
    next_tdiv = ttick ? 12'h000 : tdiv + 12'h001;
    next_prbs = ttick ? {prbs[7:0], prbs[8] ^ prbs[4]} : prbs;
    next_rxh = ttick ? {rxh[7:0], test_m[1]} : rxh;
    next_ttx = ttick ? prbs[8] : test_tx_bit;
    next_terr = ttick && (test_m[1] != (rxh[8] ^ rxh[4]));
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tdiv <= '0;
      prbs <= 9'h1FF;
      rxh <= '0;
      {test_tx_bit, test_error} <= '0;
    end else begin
      tdiv <= next_tdiv;
      prbs <= next_prbs;
      rxh <= next_rxh;
      test_tx_bit <= next_ttx;
      test_error <= next_terr;
    end
  end

  // receive framer on the link clock
  logic [1:0] md_r0, md_r1, frc_r;
  logic [3:0] fifo, next_fifo;
  logic [1:0] wp;
  logic [2:0] rbit, next_rbit, grp, next_grp, pgrp, next_pgrp, good, next_good, bad, next_bad;
  logic [4:0] rch, next_rch, rfrm, next_rfrm;
  logic rfb, next_rfb, rb, chk, ok, slip, next_sync, next_remote;
  logic [1:0] fh, next_fh;
  logic [7:0] rword;
  logic [3:0] rem_cnt, next_rem_cnt;
  tcmf_pkg::tcmf_mode_e rmode;
  assign rmode = tcmf_pkg::tcmf_mode_e'(md_r1);
  assign rb = fifo[wp + 2'h2];
  always_comb begin
    next_fifo = fifo;
    next_fifo[wp] = aggregate_rx_data;
    next_fh = fh;
    next_grp = grp;
    next_pgrp = pgrp;
    chk = 1'b0;
    ok = 1'b0;
    if (rmode == tcmf_pkg::MD_24) begin
      if (rfb) begin
        next_fh = {fh[0], rb};
        chk = !rfrm[0];
        ok = (rb != fh[1]);
      end
    end else if (rbit == 3'h7 && rch < 5'h03 &&
                 (rfrm == `TCMF_FR_FRM_A || rfrm == `TCMF_FR_FRM_B)) begin
      next_grp[rch[1:0]] = rb;
      if (rch == 5'h02) begin
        next_pgrp = {rb, grp[1:0]};
        chk = 1'b1;
        ok = ({rb, grp[1:0]} == ~pgrp) &&
             ({rb, grp[1:0]} == `TCMF_GRP_A || {rb, grp[1:0]} == `TCMF_GRP_B);
      end
    end
    next_good = good;
    next_bad = bad;
    next_sync = rx_sync;
    slip = 1'b0;
    if (chk && ok) begin
      next_bad = 3'h0;
      if (good != `TCMF_SYNC_GOOD) next_good = good + 3'h1;
      if (good == `TCMF_SYNC_GOOD - 3'h1) next_sync = 1'b1;
    end else if (chk) begin
      next_good = 3'h0;
      next_bad = bad + 3'h1;
      if (!rx_sync || bad == `TCMF_SYNC_BAD - 3'h1) begin
        next_sync = 1'b0;
        next_bad = 3'h0;
        slip = 1'b1;
      end
    end
    next_rbit = rbit;
    next_rch = rch;
    next_rfrm = rfrm;
    next_rfb = rfb;
    if (slip) begin
      next_rbit = rbit; // hold one bit time to walk the alignment
    end else if (rfb) begin
      next_rfb = 1'b0;
    end else if (rbit == 3'h7) begin
      next_rbit = 3'h0;
      if (rch == last_ch(rmode)) begin
        next_rch = 5'h00;
        next_rfb = (rmode == tcmf_pkg::MD_24);
        if (rfrm == ((rmode == tcmf_pkg::MD_24) ? `TCMF_FR_SIG_B24 : `TCMF_FR_FRM_B))
          next_rfrm = 5'h00;
        else
          next_rfrm = rfrm + 5'h01;
      end else begin
        next_rch = rch + 5'h01;
      end
    end else begin
      next_rbit = rbit + 3'h1;
    end
    next_rem_cnt = rem_cnt;
    next_remote = rx_remote;
    if (!rfb && rch == 5'h00 && rbit == 3'h7) begin
      if (rx_sync && {rword[6:0], rb} == `TCMF_ALARM_BYTE) begin
        if (rem_cnt != `TCMF_REMOTE_FRAMES) next_rem_cnt = rem_cnt + 4'h1;
        next_remote = (rem_cnt >= `TCMF_REMOTE_FRAMES - 4'h1);
      end else begin
        next_rem_cnt = 4'h0;
        next_remote = 1'b0;
      end
    end
  end
  always_ff @(posedge aggregate_rx_clock or posedge rst) begin
    if (rst) begin
      {rx_tog, rx_sync, rx_remote, md_r0, md_r1, frc_r, fifo, wp} <= '0;
      {rbit, grp, pgrp, good, bad, rch, rfrm, rfb, fh, rword, rem_cnt} <= '0;
      {rx_chan_data, rx_chan_index, rx_bit_index} <= '0;
    end else begin
      rx_tog <= !rx_tog;
      md_r0 <= cfg.mode;
      md_r1 <= md_r0;
      frc_r <= {frc_r[0], data_all_ones};
      fifo <= next_fifo;
      wp <= wp + 2'h1;
      {rbit, rch, rfrm, rfb} <= {next_rbit, next_rch, next_rfrm, next_rfb};
      {grp, pgrp, fh, good, bad} <= {next_grp, next_pgrp, next_fh, next_good, next_bad};
      rx_sync <= next_sync;
      rword <= {rword[6:0], rb};
      rem_cnt <= next_rem_cnt;
      rx_remote <= next_remote;
      rx_chan_data <= frc_r[1] | rb;
      rx_chan_index <= rch;
      rx_bit_index <= rbit;
    end
  end

  logic [2:0] bsel;
  assign bsel = 3'h7 - bit_i;
  sequence s_bip;
    cfg.bipolar ##1 cfg.bipolar;
  endsequence
  strobe_onehot_a: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(channel_select_strobes)) else $error("strobes not one-hot");
  alarm_byte_a: assert property (@(posedge mclk) disable iff (rst)
    tick && force_tx && !fb && !smallf |=> aggregate_tx_data == ALARM[$past(bsel)])
    else $error("alarm pattern bit wrong");
  clk_off_a: assert property (@(posedge mclk) disable iff (rst)
    s_bip |-> !aggregate_tx_clock_oe) else $error("tx clock driven in bipolar");
  ext_lock_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(ext_on) |-> $past(ext_edge)) else $error("external lock without edge");
  busy_force_a: assert property (@(posedge mclk) disable iff (rst)
    (|alarm_status) |-> voice_busy && data_all_ones) else $error("alarm without busy-out");
  loop_force_a: assert property (@(posedge mclk) disable iff (rst)
    loop_local || loop_remote |=> voice_busy ##0 data_all_ones) else $error("loop not forced");
  alarm_clear_a: assert property (@(posedge mclk) disable iff (rst)
    !(|alarm_status) && !$past(loop_local) && !$past(loop_remote) |-> !voice_busy)
    else $error("busy held after clear");
  fb24_bit_a: assert property (@(posedge mclk) disable iff (rst)
    tick && fb |=> aggregate_tx_data == FB24[$past(frm[3:0])])
    else $error("framing bit wrong");
  grp_bit_a: assert property (@(posedge mclk) disable iff (rst)
    tick && smallf && !fb && ch == 5'h02 && frm == `TCMF_FR_FRM_A |=> aggregate_tx_data)
    else $error("small-mode framing bit wrong");
  rx_slip_a: assert property (@(posedge aggregate_rx_clock) disable iff (rst)
    chk && !ok && !rx_sync |=> rbit == $past(rbit) && !rx_sync) else $error("no slip");
  rx_ones_a: assert property (@(posedge aggregate_rx_clock) disable iff (rst)
    frc_r[1] |=> rx_chan_data) else $error("rx data not forced");
endmodule // tcmf_framer
`default_nettype wire

/* File: verif/tcmf_far_end.sv */
// far-end terminal model: sends a 24-channel aggregate stream to the framer
// assumes the framer runs in 24-channel mode; link clock period 32 ns
`timescale 1ns/1ps
`default_nettype none
`include "tcmf_cfg.svh"
module tcmf_far_end (
  input  wire logic run,
  input  wire logic send_alarm,
  output logic      rx_clock,
  output logic      rx_data
);
  localparam logic [11:0] FB = `TCMF_FB24;
  logic [7:0] pos;
  logic [3:0] frame;
  logic [7:0] word;
  initial begin
    rx_clock = 1'b0;
    rx_data = 1'b0;
    // phase picked so the framer's bit and channel counters, reset together with run, start aligned; its frame count starts one ahead
    pos = 8'h03;
    frame = 4'hB;
    #3;
    forever begin
      if (run) begin
        word = send_alarm ? `TCMF_ALARM_BYTE : 8'hC3;
        if (pos == 8'h00) rx_data = FB[frame];
        else if (pos <= 8'h08) rx_data = word[8'h08 - pos];
        else rx_data = send_alarm | (pos[0] ^ frame[0]);
        #16 rx_clock = 1'b1;
        #16 rx_clock = 1'b0;
        pos = (pos == 8'hC0) ? 8'h00 : pos + 8'h01;
        if (pos == 8'h00) frame = (frame == 4'hB) ? 4'h0 : frame + 4'h1;
      end else begin
        // clock stopped: the line is not held, so keep it moving
        #16 rx_data = ~rx_data;
        #16;
      end
    end
  end
endmodule // tcmf_far_end
`default_nettype wire

/* File: verif/tdm_channel_mux_framer_tb.sv */
// testbench of the channel multiplexer framer with a far-end model
// assumes tcmf_pkg compiled first; mclk 8 ns, link clock from the model
`timescale 1ns/1ps
`default_nettype none
module tdm_channel_mux_framer_tb;
  logic mclk, rst, ext_timing, loop_local, loop_remote, chan_tx_bit, sig_tx_bit;
  logic async_in, tx_line_ok, test_rx_bit, run, send_alarm, rx_clock, rx_data;
  logic tx_data, tx_clk, tx_oe, voice_busy, data_all_ones, rga, test_tx, test_error;
  logic rx_chan_data, rx_in_sync;
  logic [4:0] rx_chan_index;
  logic [2:0] rx_bit_index;
  logic [23:0] strobes, prev, exp;
  tcmf_pkg::tcmf_cfg_s cfg;
  tcmf_pkg::tcmf_slot_e slot_type [24];
  tcmf_pkg::tcmf_alarm_s alarm;
  int mismatches, compares, seed, i, k, n;
  logic [31:0] r;

  tcmf_far_end u_far (.run(run), .send_alarm(send_alarm), .rx_clock(rx_clock),
    .rx_data(rx_data));
  tcmf_framer #(.TX_DIV(8), .EXT_WIN(16), .LOS_CYC(64)) u_dut (
    .mclk(mclk), .rst(rst), .aggregate_rx_clock(rx_clock), .aggregate_rx_data(rx_data),
    .ext_timing(ext_timing), .cfg(cfg), .slot_type(slot_type), .loop_local(loop_local),
    .loop_remote(loop_remote), .chan_tx_bit(chan_tx_bit), .sig_tx_bit(sig_tx_bit),
    .async_in(async_in), .tx_line_ok(tx_line_ok), .test_rx_bit(test_rx_bit),
    .aggregate_tx_data(tx_data), .aggregate_tx_clock(tx_clk),
    .aggregate_tx_clock_oe(tx_oe), .channel_select_strobes(strobes),
    .alarm_status(alarm), .voice_busy(voice_busy), .data_all_ones(data_all_ones),
    .remote_group_alarm(rga), .test_tx_bit(test_tx), .test_error(test_error),
    .rx_chan_data(rx_chan_data), .rx_chan_index(rx_chan_index),
    .rx_bit_index(rx_bit_index), .rx_in_sync(rx_in_sync));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    r = $random(seed);
    chan_tx_bit <= r[0];
    sig_tx_bit <= r[1];
    async_in <= r[2];
    test_rx_bit <= r[3];
  end

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic cmp_bit(input logic got, input logic want, input string what);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, want);
    end
  endtask

  task automatic cmp_vec(input logic [23:0] got, input logic [23:0] want, input string what);
    compares++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, want);
    end
  endtask

  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // data trails its strobe by one bit time: first sample is the last bit of the word before
  task automatic check_tx(input int words);
    prev = strobes;
    for (int w = 0; w < words; w++) begin
      for (n = 0; n < 200 && strobes === prev; n++) tick();
      exp = (prev == 24'h0) ? 24'h1 : prev << 1;
      if (w > 0) cmp_vec(strobes, exp, "strobe order");
      prev = strobes;
      for (k = 0; k < 8 && strobes != 24'h0; k++) begin
        repeat (k == 0 ? 3 : 8) tick();
        if (k > 0 || exp != 24'h1) cmp_bit(tx_data, k == 0 || k >= 5, "alarm byte bit");
      end
    end
  endtask

  initial begin
    #(8 * 80000);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  initial begin
    seed = 32'h0bcc;
    mismatches = 0;
    compares = 0;
    {rst, ext_timing, loop_local, loop_remote, tx_line_ok, run, send_alarm} = 7'h44;
    {chan_tx_bit, sig_tx_bit, async_in, test_rx_bit} = 4'h0;
    cfg = '{mode: tcmf_pkg::MD_24, bipolar: 1'b0, mr_rate: tcmf_pkg::RT_64,
            mr_base: 5'h00, test_rate: 2'h0};
    for (i = 0; i < 24; i++) slot_type[i] = tcmf_pkg::SL_VOICE;
    repeat (5) tick();
    cmp_vec(strobes, 24'h0, "strobes in reset");
    cmp_bit(voice_busy, 1'b0, "busy in reset");
    @(posedge mclk) rst <= 1'b0;
    run <= 1'b1;
    repeat (2) tick();
    cmp_bit(tx_oe, 1'b1, "clock enable in nrz");
    for (n = 0; n < 20 && alarm.loss_frame !== 1'b1; n++) tick();
    cmp_bit(alarm.loss_frame, 1'b1, "unsynced after reset");
    cmp_bit(voice_busy, 1'b1, "busy while unsynced");
    test_done("reset");
    check_tx(28);
    test_done("alarm pattern");
    for (n = 0; n < 60000 && rx_in_sync !== 1'b1; n++) tick();
    cmp_bit(rx_in_sync, 1'b1, "frame sync");
    repeat (20) tick();
    cmp_bit(alarm.loss_frame, 1'b0, "frame loss cleared");
    cmp_bit(data_all_ones, 1'b0, "service resumed");
    test_done("sync");
    @(posedge mclk) tx_line_ok <= 1'b0;
    repeat (20) tick();
    cmp_bit(alarm.loss_output, 1'b1, "output loss");
    cmp_bit(voice_busy & data_all_ones, 1'b1, "busy on output loss");
    @(posedge mclk) tx_line_ok <= 1'b1;
    repeat (20) tick();
    cmp_bit(voice_busy | alarm.loss_output, 1'b0, "output loss cleared");
    test_done("output loss");
    for (i = 0; i < 2; i++) begin
      @(posedge mclk) {loop_local, loop_remote} <= (i == 0) ? 2'h2 : 2'h1;
      repeat (20) tick();
      cmp_bit(voice_busy & data_all_ones, 1'b1, "busy on loop test");
      for (k = 0; k < 16; k++) begin
        @(posedge rx_clock);
        #1;
        cmp_bit(rx_chan_data, 1'b1, "forced ones");
      end
      @(posedge mclk) {loop_local, loop_remote} <= 2'h0;
      repeat (10) tick();
      cmp_bit(data_all_ones, 1'b0, "loop released");
    end
    test_done("loops");
    @(posedge mclk) send_alarm <= 1'b1;
    for (n = 0; n < 12000 && rga !== 1'b1; n++) tick();
    cmp_bit(rga, 1'b1, "remote group alarm");
    cmp_bit(alarm.remote & voice_busy, 1'b1, "remote busy");
    @(posedge mclk) send_alarm <= 1'b0;
    for (n = 0; n < 2500 && rga !== 1'b0; n++) tick();
    cmp_bit(rga, 1'b0, "remote cleared");
    test_done("remote alarm");
    @(posedge mclk) run <= 1'b0;
    for (n = 0; n < 300 && alarm.loss_input !== 1'b1; n++) tick();
    cmp_bit(alarm.loss_input, 1'b1, "input loss");
    @(posedge mclk) run <= 1'b1;
    for (n = 0; n < 300 && alarm.loss_input !== 1'b0; n++) tick();
    cmp_bit(alarm.loss_input, 1'b0, "input loss cleared");
    test_done("input loss");
    for (n = 0; n < 5000 && test_error !== 1'b1; n++) tick();
    cmp_bit(test_error, 1'b1, "test error seen");
    test_done("test unit");
    @(posedge mclk) rst <= 1'b1;
    cfg.bipolar <= 1'b1;
    repeat (3) tick();
    @(posedge mclk) rst <= 1'b0;
    repeat (3) tick();
    cmp_bit(tx_oe, 1'b0, "no clock in bipolar");
    test_done("bipolar");
    end_of_test();
  end
endmodule // tdm_channel_mux_framer_tb
`default_nettype wire
